// file: rtl/ccm_map.svh
// Register offsets, field positions, reset values and timing counts of the CC match logic
`ifndef CCM_MAP_SVH
`define CCM_MAP_SVH

// Byte offsets on the APB register window
`define CCM_OFS_CTRL 12'h000
`define CCM_OFS_DEB_TIME 12'h004
`define CCM_OFS_CC1_DBCLR 12'h008
`define CCM_OFS_CC1_MEN 12'h00C
`define CCM_OFS_CC2_DBCLR 12'h010
`define CCM_OFS_CC2_MEN 12'h014
`define CCM_OFS_CC1_MATCH 12'h018
`define CCM_OFS_CC2_MATCH 12'h01C
`define CCM_OFS_CC1_CHG 12'h020
`define CCM_OFS_CC2_CHG 12'h024
`define CCM_OFS_INT_STS 12'h028
`define CCM_OFS_INT_MASK 12'h02C
`define CCM_OFS_STATUS 12'h030
`define CCM_OFS_THR_BASE 12'h040
`define CCM_OFS_THR_LAST 12'h05C

// Field positions
`define CCM_CTRL_DEB_EN 0
`define CCM_INT_VALID 0
`define CCM_INT_CC1_CHG 1
`define CCM_INT_CC2_CHG 2
`define CCM_STAT_DEB_ACTIVE 0
`define CCM_STAT_VALID 1

// Reset values
`define CCM_RST_DEB_TIME 16'h000A
`define CCM_RST_MASK 8'h00

// Default threshold levels in millivolts, index 0 to 7
`define CCM_THR0_MV 16'h00C8
`define CCM_THR1_MV 16'h0190
`define CCM_THR2_MV 16'h0294
`define CCM_THR3_MV 16'h0320
`define CCM_THR4_MV 16'h04CE
`define CCM_THR5_MV 16'h0640
`define CCM_THR6_MV 16'h0A28
`define CCM_THR7_MV 16'h0BB8

// Timing: debounce unit and clock period in nanoseconds
`define CCM_DEB_UNIT_NS 1000
`define CCM_CLK_PERIOD_NS 10
`define CCM_US_CYCLES (`CCM_DEB_UNIT_NS / `CCM_CLK_PERIOD_NS)

`endif

// file: rtl/ccm_pkg.sv
// Shared types of the CC match logic
package ccm_pkg;
   typedef logic [7:0] ccm_vec_t;
   typedef logic [15:0] ccm_level_t;
   typedef enum logic [1:0] {CCM_DEB_IDLE, CCM_DEB_SETTLE, CCM_DEB_STABLE} ccm_deb_st_t;
endpackage

// file: rtl/ccm_deb_if.sv
// Control and result bundle between the top and one per-pin debouncer
`timescale 1ns/1ns
`default_nettype none
interface ccm_deb_if;
   logic enable;
   ccm_pkg::ccm_vec_t mask;
   logic [15:0] deb_us;
   ccm_pkg::ccm_vec_t raw;
   ccm_pkg::ccm_vec_t match;
   ccm_pkg::ccm_vec_t chg_evt;
   logic first_done;
   logic changed;
   modport ctl (output enable, output mask, output deb_us, output raw,
                input match, input chg_evt, input first_done, input changed);
   modport deb (input enable, input mask, input deb_us, input raw,
                output match, output chg_evt, output first_done, output changed);
endinterface
`default_nettype wire

// file: rtl/ccm_thr_mem.sv
// Threshold level store: one word per index, CC1 level low half, CC2 level high half
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"
module ccm_thr_mem
#(
   parameter int DEPTH = 8,
   parameter int AW = 3
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Write port
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [31:0] i_wdata,
   // Registered read ports
   input wire logic [AW-1:0] i_raddr_a,
   output logic [31:0] o_rdata_a,
   input wire logic [AW-1:0] i_raddr_b,
   output logic [31:0] o_rdata_b
);
   logic [31:0] mem_r [DEPTH];

   initial
   begin
      if (DEPTH != 8 || (1 << AW) != DEPTH)
         $error("ccm_thr_mem: only eight entries are served");
   end

   function automatic logic [15:0] dflt(input int idx);
      case (idx)
         0: dflt = `CCM_THR0_MV;
         1: dflt = `CCM_THR1_MV;
         2: dflt = `CCM_THR2_MV;
         3: dflt = `CCM_THR3_MV;
         4: dflt = `CCM_THR4_MV;
         5: dflt = `CCM_THR5_MV;
         6: dflt = `CCM_THR6_MV;
         default: dflt = `CCM_THR7_MV;
      endcase
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_word
         always_ff @(posedge i_core_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
               mem_r[gi] <= {dflt(gi), dflt(gi)};
            else if (i_clk_en && i_we && i_waddr == AW'(gi))
               mem_r[gi] <= i_wdata;
         end
      end
   endgenerate

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rdata_a <= 32'h00000000;
         o_rdata_b <= 32'h00000000;
      end
      else if (i_clk_en)
      begin
         o_rdata_a <= mem_r[i_raddr_a];
         o_rdata_b <= mem_r[i_raddr_b];
      end
   end
endmodule // ccm_thr_mem
`default_nettype wire

// file: rtl/ccm_pin_deb.sv
// Per-pin debouncer: masks, makes matches cumulative and commits them after the interval
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"
module ccm_pin_deb
#(
   parameter int US_CYCLES = `CCM_US_CYCLES
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // Link to the top
   ccm_deb_if.deb bus
);
   ccm_pkg::ccm_deb_st_t st_r;
   ccm_pkg::ccm_vec_t hit;
   ccm_pkg::ccm_vec_t cum;
   ccm_pkg::ccm_vec_t cand_r;
   logic [15:0] pre_r;
   logic [15:0] us_r;

   initial
   begin
      if (US_CYCLES < 1 || US_CYCLES > 65535)
         $error("ccm_pin_deb: US_CYCLES out of range");
   end

   assign hit = bus.raw & bus.mask;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_cum
         // A higher enabled crossing also reports every lower enabled threshold
         assign cum[gi] = bus.mask[gi] & (|hit[7:gi]);
      end
   endgenerate

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_r <= ccm_pkg::CCM_DEB_IDLE;
         cand_r <= 8'h00;
         pre_r <= 16'h0000;
         us_r <= 16'h0000;
         bus.match <= 8'h00;
         bus.chg_evt <= 8'h00;
         bus.first_done <= 1'b0;
         bus.changed <= 1'b0;
      end
      else if (i_clk_en)
      begin
         bus.chg_evt <= 8'h00;
         bus.changed <= 1'b0;
         case (st_r)
            ccm_pkg::CCM_DEB_IDLE:
            begin
               bus.first_done <= 1'b0;
               if (bus.enable)
               begin
                  cand_r <= cum;
                  pre_r <= 16'h0000;
                  us_r <= 16'h0000;
                  st_r <= ccm_pkg::CCM_DEB_SETTLE;
               end
            end
            ccm_pkg::CCM_DEB_SETTLE:
            begin
               if (!bus.enable)
                  st_r <= ccm_pkg::CCM_DEB_IDLE;
               else if (cum != cand_r)
               begin
                  // Any bounce restarts the interval
                  cand_r <= cum;
                  pre_r <= 16'h0000;
                  us_r <= 16'h0000;
               end
               else if (us_r >= bus.deb_us)
               begin
                  bus.match <= cand_r;
                  bus.chg_evt <= cand_r ^ bus.match;
                  bus.changed <= |(cand_r ^ bus.match);
                  bus.first_done <= 1'b1;
                  st_r <= ccm_pkg::CCM_DEB_STABLE;
               end
               else if (pre_r == 16'(US_CYCLES - 1))
               begin
                  pre_r <= 16'h0000;
                  us_r <= us_r + 16'h0001;
               end
               else
                  pre_r <= pre_r + 16'h0001;
            end
            default:
            begin
               if (!bus.enable)
                  st_r <= ccm_pkg::CCM_DEB_IDLE;
               else if (cum != cand_r)
               begin
                  cand_r <= cum;
                  pre_r <= 16'h0000;
                  us_r <= 16'h0000;
                  st_r <= ccm_pkg::CCM_DEB_SETTLE;
               end
            end
         endcase
      end
   end
endmodule // ccm_pin_deb
`default_nettype wire

// file: rtl/ccm_match_top.sv
// CC threshold match logic: APB registers, comparator sync, two pin debouncers, interrupt
// Overview of operation
// - Eight thresholds per CC pin; index n is bit n of match and change results.
// - Reset levels ascend 0.20 V to 2.60 V; index 7 is 3.0 V vendor level.
// - As sink, changes in crossed source threshold are detected and reported.
// - Source cable detect uses index 0 default, 1 for 1.5A, 3 for 3.0A.
// - Sink source-detect uses index 0 default, 2 for 1.5A, 4 for 3.0A.
// - Source sink-detect uses index 5 for default and 1.5A, 6 for 3.0A.
// - Sink results: none, bit 0, bits 0,2, bits 0,2,4, bits 0,2,4,7.
// - Source open line: bits 0,5; 1,5; 3,6; or bit 7 alone.
// - Source with sink: bit 0, 1 or 3; powered cable only gives none.
// - Software sets equal masks; only thresholds enabled in both are evaluated.
// - After the debounce interval matches appear in match and change registers.
// - Exceeding a higher enabled threshold also matches every lower enabled one.
// - Valid flag after both pins' first debounce; per-pin change events flagged.
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"
module ccm_match_top
#(
   parameter int NUM_THR = 8,
   parameter int US_CYCLES = `CCM_US_CYCLES
)
(
   // Clock, reset, clock enable
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Analog comparator results, one bit per threshold index
   input wire logic [7:0] i_cmp_cc1,
   input wire logic [7:0] i_cmp_cc2,
   // Threshold levels towards the DAC, scanned index by index
   output logic [2:0] o_dac_idx,
   output logic [15:0] o_dac_level_cc1,
   output logic [15:0] o_dac_level_cc2,
   // Interrupt
   output logic o_irq
);
   initial
   begin
      if (NUM_THR != 8)
         $error("ccm_match_top: exactly eight thresholds per pin are served");
   end

   ccm_deb_if deb1 ();
   ccm_deb_if deb2 ();

   logic deb_en_r;
   logic [15:0] deb_time_r;
   ccm_pkg::ccm_vec_t cc1_dbclr_r;
   ccm_pkg::ccm_vec_t cc1_men_r;
   ccm_pkg::ccm_vec_t cc2_dbclr_r;
   ccm_pkg::ccm_vec_t cc2_men_r;
   ccm_pkg::ccm_vec_t cc1_chg_r;
   ccm_pkg::ccm_vec_t cc2_chg_r;
   logic [2:0] int_sts_r;
   logic [2:0] int_mask_r;
   logic valid_seen_r;
   logic [7:0] cc1_s1_r;
   logic [7:0] cc1_s2_r;
   logic [7:0] cc2_s1_r;
   logic [7:0] cc2_s2_r;
   logic pend_r;
   logic [2:0] scan_r;
   logic [2:0] scan_d_r;
   logic [31:0] thr_rd_a;
   logic [31:0] thr_rd_b;
   logic wr_go;
   logic is_thr;
   logic [2:0] thr_idx;
   logic [31:0] rd_nxt;
   logic map_hit;
   logic valid_evt;
   logic [2:0] int_evt;
   logic [2:0] int_w1c;
   ccm_pkg::ccm_vec_t cc1_w1c;
   ccm_pkg::ccm_vec_t cc2_w1c;

   // Comparator outputs are asynchronous to the core clock
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cc1_s1_r <= 8'h00;
         cc1_s2_r <= 8'h00;
         cc2_s1_r <= 8'h00;
         cc2_s2_r <= 8'h00;
      end
      else if (i_clk_en)
      begin
         cc1_s1_r <= i_cmp_cc1;
         cc1_s2_r <= cc1_s1_r;
         cc2_s1_r <= i_cmp_cc2;
         cc2_s2_r <= cc2_s1_r;
      end
   end

   // Both masks must agree, so a threshold counts only where both are set
   assign deb1.enable = deb_en_r;
   assign deb1.mask = cc1_dbclr_r & cc1_men_r;
   assign deb1.deb_us = deb_time_r;
   assign deb1.raw = cc1_s2_r;
   assign deb2.enable = deb_en_r;
   assign deb2.mask = cc2_dbclr_r & cc2_men_r;
   assign deb2.deb_us = deb_time_r;
   assign deb2.raw = cc2_s2_r;

   // One debouncer per pin keeps the two pins' results apart
   ccm_pin_deb #(.US_CYCLES(US_CYCLES)) u_deb_cc1
   (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .bus(deb1.deb)
   );

   ccm_pin_deb #(.US_CYCLES(US_CYCLES)) u_deb_cc2
   (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .bus(deb2.deb)
   );

   // APB decode
   assign wr_go = i_psel & i_penable & o_pready & i_pwrite;
   assign is_thr = (i_paddr >= `CCM_OFS_THR_BASE) && (i_paddr <= `CCM_OFS_THR_LAST)
                   && (i_paddr[1:0] == 2'b00);
   assign thr_idx = i_paddr[4:2];

   ccm_thr_mem #(.DEPTH(NUM_THR), .AW(3)) u_thr_mem
   (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_we(wr_go & is_thr),
      .i_waddr(thr_idx),
      .i_wdata(i_pwdata),
      .i_raddr_a(thr_idx),
      .o_rdata_a(thr_rd_a),
      .i_raddr_b(scan_r),
      .o_rdata_b(thr_rd_b)
   );

   always_comb
   begin
      rd_nxt = 32'h00000000;
      map_hit = 1'b1;
      if (i_paddr == `CCM_OFS_CTRL)
         rd_nxt[`CCM_CTRL_DEB_EN] = deb_en_r;
      else if (i_paddr == `CCM_OFS_DEB_TIME)
         rd_nxt[15:0] = deb_time_r;
      else if (i_paddr == `CCM_OFS_CC1_DBCLR)
         rd_nxt[7:0] = cc1_dbclr_r;
      else if (i_paddr == `CCM_OFS_CC1_MEN)
         rd_nxt[7:0] = cc1_men_r;
      else if (i_paddr == `CCM_OFS_CC2_DBCLR)
         rd_nxt[7:0] = cc2_dbclr_r;
      else if (i_paddr == `CCM_OFS_CC2_MEN)
         rd_nxt[7:0] = cc2_men_r;
      else if (i_paddr == `CCM_OFS_CC1_MATCH)
         rd_nxt[7:0] = deb1.match;
      else if (i_paddr == `CCM_OFS_CC2_MATCH)
         rd_nxt[7:0] = deb2.match;
      else if (i_paddr == `CCM_OFS_CC1_CHG)
         rd_nxt[7:0] = cc1_chg_r;
      else if (i_paddr == `CCM_OFS_CC2_CHG)
         rd_nxt[7:0] = cc2_chg_r;
      else if (i_paddr == `CCM_OFS_INT_STS)
         rd_nxt[2:0] = int_sts_r;
      else if (i_paddr == `CCM_OFS_INT_MASK)
         rd_nxt[2:0] = int_mask_r;
      else if (i_paddr == `CCM_OFS_STATUS)
      begin
         rd_nxt[`CCM_STAT_DEB_ACTIVE] = deb_en_r;
         rd_nxt[`CCM_STAT_VALID] = valid_seen_r;
      end
      else if (is_thr)
         rd_nxt = thr_rd_a;
      else
         map_hit = 1'b0;
   end

   // One wait state lets the threshold store's registered read settle for every access
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pend_r <= 1'b0;
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
      end
      else if (i_clk_en)
      begin
         pend_r <= i_psel & ~i_penable & ~pend_r & ~o_pready;
         o_pready <= pend_r & i_psel;
         if (pend_r)
         begin
            o_prdata <= i_pwrite ? 32'h00000000 : rd_nxt;
            o_pslverr <= ~map_hit;
         end
         else if (o_pready)
         begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
         end
      end
   end

   // Control and mask registers
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         deb_en_r <= 1'b0;
         deb_time_r <= `CCM_RST_DEB_TIME;
         cc1_dbclr_r <= `CCM_RST_MASK;
         cc1_men_r <= `CCM_RST_MASK;
         cc2_dbclr_r <= `CCM_RST_MASK;
         cc2_men_r <= `CCM_RST_MASK;
         int_mask_r <= 3'h0;
      end
      else if (i_clk_en && wr_go)
      begin
         if (i_paddr == `CCM_OFS_CTRL)
            deb_en_r <= i_pwdata[`CCM_CTRL_DEB_EN];
         else if (i_paddr == `CCM_OFS_DEB_TIME)
            deb_time_r <= i_pwdata[15:0];
         else if (i_paddr == `CCM_OFS_CC1_DBCLR)
            cc1_dbclr_r <= i_pwdata[7:0];
         else if (i_paddr == `CCM_OFS_CC1_MEN)
            cc1_men_r <= i_pwdata[7:0];
         else if (i_paddr == `CCM_OFS_CC2_DBCLR)
            cc2_dbclr_r <= i_pwdata[7:0];
         else if (i_paddr == `CCM_OFS_CC2_MEN)
            cc2_men_r <= i_pwdata[7:0];
         else if (i_paddr == `CCM_OFS_INT_MASK)
            int_mask_r <= i_pwdata[2:0];
      end
   end

   // Write-one-to-clear strobes
   assign cc1_w1c = (wr_go && i_paddr == `CCM_OFS_CC1_CHG) ? i_pwdata[7:0] : 8'h00;
   assign cc2_w1c = (wr_go && i_paddr == `CCM_OFS_CC2_CHG) ? i_pwdata[7:0] : 8'h00;
   assign int_w1c = (wr_go && i_paddr == `CCM_OFS_INT_STS) ? i_pwdata[2:0] : 3'h0;

   // Change flags: a new event in the clearing cycle survives the clear
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cc1_chg_r <= 8'h00;
         cc2_chg_r <= 8'h00;
      end
      else if (i_clk_en)
      begin
         cc1_chg_r <= (cc1_chg_r & ~cc1_w1c) | deb1.chg_evt;
         cc2_chg_r <= (cc2_chg_r & ~cc2_w1c) | deb2.chg_evt;
      end
   end

   // Valid is reported once per debounce enable, when both pins have settled
   assign valid_evt = deb1.first_done & deb2.first_done & ~valid_seen_r;
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         valid_seen_r <= 1'b0;
      else if (i_clk_en)
      begin
         if (!deb_en_r)
            valid_seen_r <= 1'b0;
         else if (valid_evt)
            valid_seen_r <= 1'b1;
      end
   end

   always_comb
   begin
      int_evt = 3'h0;
      int_evt[`CCM_INT_VALID] = valid_evt;
      int_evt[`CCM_INT_CC1_CHG] = deb1.changed;
      int_evt[`CCM_INT_CC2_CHG] = deb2.changed;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         int_sts_r <= 3'h0;
         o_irq <= 1'b0;
      end
      else if (i_clk_en)
      begin
         int_sts_r <= (int_sts_r & ~int_w1c) | int_evt;
         o_irq <= |(((int_sts_r & ~int_w1c) | int_evt) & int_mask_r);
      end
   end

   // DAC scan: the index and its levels leave together, one index per cycle
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         scan_r <= 3'h0;
         scan_d_r <= 3'h0;
         o_dac_idx <= 3'h0;
         o_dac_level_cc1 <= 16'h0000;
         o_dac_level_cc2 <= 16'h0000;
      end
      else if (i_clk_en)
      begin
         scan_r <= scan_r + 3'h1;
         scan_d_r <= scan_r;
         o_dac_idx <= scan_d_r;
         o_dac_level_cc1 <= thr_rd_b[15:0];
         o_dac_level_cc2 <= thr_rd_b[31:16];
      end
   end

   // Result encodings need no decoding here: with the masks software picks,
   // cumulative matches give the sink patterns and the source single or pair
   // patterns directly
endmodule // ccm_match_top
`default_nettype wire

// file: sim/ccm_match_assertions.sv
// Port-level assertions of the CC match logic
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"
module ccm_match_assertions
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Scan and interrupt
   input wire logic [2:0] o_dac_idx,
   input wire logic o_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence setup_s;
      i_psel && !i_penable && !o_pready;
   endsequence
   sequence answer_s;
      !o_pready ##1 o_pready;
   endsequence

   pready_delay_a: assert property (setup_s |=> answer_s)
      else $error("ready not in second access cycle");
   pready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   rdata_idle_a: assert property ((!o_pready || i_pwrite) |-> o_prdata == 32'h0)
      else $error("read data outside a read answer");
   unmapped_err_a: assert property (o_pready && i_paddr > `CCM_OFS_THR_LAST |-> o_pslverr)
      else $error("unmapped access without error");
   mapped_ok_a: assert property (o_pready && i_paddr == `CCM_OFS_CTRL |-> !o_pslverr)
      else $error("error on a mapped register");
   match_width_a: assert property (o_pready && !i_pwrite && (i_paddr == `CCM_OFS_CC1_MATCH
      || i_paddr == `CCM_OFS_CC2_MATCH) |-> o_prdata[31:8] == 24'h0)
      else $error("match wider than eight thresholds");
   dac_scan_a: assert property (o_dac_idx != 3'h0 |=> o_dac_idx == $past(o_dac_idx) + 3'h1)
      else $error("scan index skipped");
   irq_mask_a: assert property (o_pready && i_pwrite && i_paddr == `CCM_OFS_INT_MASK
      && i_pwdata[2:0] == 3'h0 |-> ##2 !o_irq)
      else $error("interrupt with all sources masked");
endmodule // ccm_match_assertions
`default_nettype wire

// file: sim/ccm_cc_partner.sv
// Far side: CC line levels seen through the threshold comparators
`timescale 1ns/1ns
`default_nettype none
module ccm_cc_partner
(
   // Clock and DAC scan
   input wire logic i_core_clk,
   input wire logic [2:0] i_dac_idx,
   input wire logic [15:0] i_dac_level_cc1,
   input wire logic [15:0] i_dac_level_cc2,
   // Line levels in millivolts
   input wire logic [15:0] i_lvl_cc1,
   input wire logic [15:0] i_lvl_cc2,
   // Comparator results
   output logic [7:0] o_cmp_cc1,
   output logic [7:0] o_cmp_cc2
);
   logic [15:0] thr1_r [8];
   logic [15:0] thr2_r [8];
   // The DAC is shared, so each level holds until its index comes round again
   always_ff @(posedge i_core_clk)
   begin
      thr1_r[i_dac_idx] <= i_dac_level_cc1;
      thr2_r[i_dac_idx] <= i_dac_level_cc2;
   end
   always_comb
   begin
      for (int n = 0; n < 8; n++)
      begin
         o_cmp_cc1[n] = i_lvl_cc1 > thr1_r[n];
         o_cmp_cc2[n] = i_lvl_cc2 > thr2_r[n];
      end
   end
endmodule // ccm_cc_partner
`default_nettype wire

// file: sim/ccm_match_top_tb.sv
// Self-checking bench of the CC match logic
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"
module ccm_match_top_tb;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic [15:0] lvl1 = 16'h0000;
   logic [15:0] lvl2 = 16'h0000;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_irq;
   logic [7:0] cmp1, cmp2;
   logic [2:0] dac_idx;
   logic [15:0] dac1, dac2;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int n_compared = 0;

   always #5 i_core_clk = ~i_core_clk;

   ccm_match_top #(.NUM_THR(8), .US_CYCLES(2)) dut (.i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cmp_cc1(cmp1), .i_cmp_cc2(cmp2),
      .o_dac_idx(dac_idx), .o_dac_level_cc1(dac1), .o_dac_level_cc2(dac2), .o_irq(o_irq));
   ccm_cc_partner u_far (.i_core_clk(i_core_clk), .i_dac_idx(dac_idx),
      .i_dac_level_cc1(dac1), .i_dac_level_cc2(dac2), .i_lvl_cc1(lvl1), .i_lvl_cc2(lvl2),
      .o_cmp_cc1(cmp1), .o_cmp_cc2(cmp2));

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One edge passes after release so back-to-back calls never drive twice at once
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do
      begin
         @(posedge i_core_clk);
         k++;
      end
      while (o_pready !== 1'b1 && k < 20);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_core_clk);
      if (k == 20)
      begin
         chk("bus answer", 32'h1, 32'h0);
         wrap_up();
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   task automatic wait_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      int k;
      k = 0;
      rd = ~exp;
      while (rd !== exp && k < 100)
      begin
         apb(1'b0, a, 32'h0);
         k++;
      end
      chk(what, exp, rd);
      if (k == 100)
         wrap_up();
   endtask

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge i_core_clk);
      chk("interrupt", {31'h0, exp}, {31'h0, o_irq});
   endtask

   task automatic t_reset_values;
      logic [15:0] dflt [8];
      dflt = '{`CCM_THR0_MV, `CCM_THR1_MV, `CCM_THR2_MV, `CCM_THR3_MV,
               `CCM_THR4_MV, `CCM_THR5_MV, `CCM_THR6_MV, `CCM_THR7_MV};
      for (int n = 0; n < 8; n++)
         rd_chk(`CCM_OFS_THR_BASE + 12'(n * 4), {dflt[n], dflt[n]}, "threshold");
      rd_chk(`CCM_OFS_DEB_TIME, 32'h0000000A, "debounce time");
      apb(1'b1, `CCM_OFS_CC1_MATCH, 32'hFF);
      rd_chk(`CCM_OFS_CC1_MATCH, 32'h0, "read-only match");
      rd_chk(12'h060, 32'h0, "unmapped read");
      chk("unmapped error", 32'h1, {31'h0, err});
   endtask

   task automatic t_sink;
      apb(1'b1, `CCM_OFS_CC1_DBCLR, 32'hFF);
      apb(1'b1, `CCM_OFS_CC1_MEN, 32'h15);
      apb(1'b1, `CCM_OFS_CC2_DBCLR, 32'h22);
      apb(1'b1, `CCM_OFS_CC2_MEN, 32'h22);
      apb(1'b1, `CCM_OFS_DEB_TIME, 32'h1);
      apb(1'b1, `CCM_OFS_INT_MASK, 32'h7);
      lvl1 <= 16'h05DC;
      lvl2 <= 16'h012C;
      apb(1'b1, `CCM_OFS_CTRL, 32'h1);
      wait_rd(`CCM_OFS_CC1_MATCH, 32'h15, "cc1 match");
      wait_rd(`CCM_OFS_INT_STS, 32'h3, "valid and cc1 event");
      rd_chk(`CCM_OFS_STATUS, 32'h3, "active and valid seen");
      rd_chk(`CCM_OFS_CC2_MATCH, 32'h0, "cc2 match");
      rd_chk(`CCM_OFS_CC1_CHG, 32'h15, "cc1 change");
      irq_chk(1'b1);
      apb(1'b1, `CCM_OFS_INT_STS, 32'h7);
      apb(1'b1, `CCM_OFS_CC1_CHG, 32'hFF);
      irq_chk(1'b0);
      lvl1 <= 16'h02BC;
      wait_rd(`CCM_OFS_CC1_MATCH, 32'h05, "cc1 match mid");
      wait_rd(`CCM_OFS_INT_STS, 32'h2, "cc1 event only");
      rd_chk(`CCM_OFS_CC1_CHG, 32'h10, "cc1 change bits");
      irq_chk(1'b1);
      apb(1'b1, `CCM_OFS_INT_MASK, 32'h0);
      irq_chk(1'b0);
      apb(1'b1, `CCM_OFS_INT_MASK, 32'h7);
   endtask

   // Each entry: pin, mask, level in mV, expected match
   task automatic t_states;
      logic [35:0] tbl [11];
      logic [7:0] prev [2];
      logic [11:0] h;
      logic [7:0] x;
      logic p;
      tbl = '{36'h0_15_00FA_01, 36'h0_15_0064_00, 36'h0_95_0C1C_95, 36'h0_95_06A4_15,
              36'h1_48_0AF0_48, 36'h1_48_03E8_08, 36'h1_48_01F4_00, 36'h1_21_012C_01,
              36'h1_21_06A4_21, 36'h1_22_01F4_02, 36'h1_80_0C1C_80};
      prev = '{8'h05, 8'h00};
      for (int e = 0; e < 11; e++)
      begin
         p = tbl[e][32];
         h = p ? 12'h004 : 12'h000;
         x = tbl[e][7:0];
         apb(1'b1, `CCM_OFS_CC1_CHG + h, 32'hFF);
         apb(1'b1, `CCM_OFS_CC1_DBCLR + h + h, {24'h0, tbl[e][31:24]});
         apb(1'b1, `CCM_OFS_CC1_MEN + h + h, {24'h0, tbl[e][31:24]});
         if (p)
            lvl2 <= tbl[e][23:8];
         else
            lvl1 <= tbl[e][23:8];
         wait_rd(`CCM_OFS_CC1_MATCH + h, {24'h0, x}, "match");
         rd_chk(`CCM_OFS_CC1_CHG + h, {24'h0, prev[p] ^ x}, "change flags");
         rd_chk(`CCM_OFS_CC1_MATCH + (h ^ 12'h004), {24'h0, prev[!p]}, "other pin");
         prev[p] = x;
      end
   endtask

   initial
   begin
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      t_reset_values();
      t_sink();
      t_states();
      wrap_up();
   end
endmodule // ccm_match_top_tb

bind ccm_match_top ccm_match_assertions u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_dac_idx(o_dac_idx), .o_irq(o_irq));
`default_nettype wire
